// ### mdpm_device.sv
// Motor drive device: sine PWM, sleep/standby control, NV parameter store
//
// What this block does
// - One phase grounded, other two modulated
// - Peak duty sets largest duty per cycle
// - Amplitude scales linearly with peak duty
// - Low-power condition stops phase drive
// - Sleep variant turns regulator off
// - Sleep disables bus, resets volatile registers
// - Standby keeps regulator, registers, bus alive
// - Inhibit blocks entry, never forces exit
// - Status bit 6 at 0x10 flags low power in standby variant only (sleep blocks bus reads)
// - Analog mode uses level thresholds and timeouts
// - PWM mode uses pin low/high durations
// - I2C mode enters on zero speed value, exits on non-zero (standby) or pin/level (sleep)
// - Host wakes sleeping device via pin or speed level
// - Twelve bytes of non-volatile parameter storage
// - Host sets load bit, then writes parameters
// - Programming accepted only after unlock key
// - Host starts programming with write-go bit
// - Programming takes 24 ms, go self-clears
// - Host programs only with speed pin low, then polls go bit until clear
// - Resistance code in parameter register A
// - Back-EMF code in parameter register B
// - NV copied to working on reset, sleep exit
// - Direct register writes override stored values
`timescale 1ns/1ns
`default_nettype none
module mdpm_device #(
	parameter bit SLEEP_VARIANT = 1'b1,
	parameter int TICK_CYCLES = mdpm_pkg::TICK_CYCLES,
	parameter int PROG_MS = mdpm_pkg::PROG_MS,
	parameter int EN_ANA_MS = mdpm_pkg::EN_ANA_MS,
	parameter int EN_PWM_MS = mdpm_pkg::EN_PWM_MS,
	parameter int EX_ANA_MS = mdpm_pkg::EX_ANA_MS,
	parameter int EX_PWM_MS = mdpm_pkg::EX_PWM_MS
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Host link
	mdpm_link_if.dev link,
	// Motor and power side
	output logic [2:0] phase_pwm,
	output logic drive_en,
	output logic regulator_en,
	output logic lowpower,
	output logic [7:0] peak_duty_cycle,
	output logic [6:0] phase_resistance_code,
	output logic [6:0] back_emf_constant_code
);
	// ----------------------------------------
	// Millisecond tick
	// ----------------------------------------
	logic [31:0] div_r;
	logic tick;
	assign tick = (div_r == 32'(TICK_CYCLES - 1));
	always_ff @(posedge core_clk) begin
		if (reset || tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 32'h1;
		end
	end

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	mdpm_pkg::mdpm_pm_t pm_r;
	logic [8:0] speed_command_value_r;
	logic [7:0] program_unlock_key_r;
	logic nv_write_go_r;
	logic load_select_r;
	logic lowpower_inhibit_r;
	logic [7:0] work_r [mdpm_pkg::NV_BYTES];
	logic [7:0] nv_mem [mdpm_pkg::NV_BYTES] = '{default: mdpm_pkg::NV_DEFAULT};
	logic [15:0] prog_ms_r;
	logic prog_done;
	logic alive;
	logic wr_ok;
	logic rd_ok;
	logic in_nv;
	logic [3:0] nv_idx;
	logic trans;
	logic sleep_enter;
	logic sleep_exit;
	mdpm_pkg::mdpm_mode_t mode;

	assign alive = !(SLEEP_VARIANT && pm_r == mdpm_pkg::PM_LOW);
	assign wr_ok = link.bus_wr && alive;
	assign rd_ok = link.bus_rd && alive;
	assign in_nv = link.bus_addr >= mdpm_pkg::ADDR_NV_FIRST && link.bus_addr <= mdpm_pkg::ADDR_NV_LAST;
	assign nv_idx = 4'(link.bus_addr - mdpm_pkg::ADDR_NV_FIRST);
	assign sleep_enter = SLEEP_VARIANT && trans && pm_r == mdpm_pkg::PM_RUN;
	assign sleep_exit = SLEEP_VARIANT && trans && pm_r == mdpm_pkg::PM_LOW;
	assign prog_done = nv_write_go_r && tick && prog_ms_r == 16'(PROG_MS - 1);
	assign mode = mdpm_pkg::mdpm_mode_t'(work_r[mdpm_pkg::IDX_MODE][1:0]);

	// ----------------------------------------
	// Volatile control registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset || sleep_enter) begin
			speed_command_value_r <= '0;
			program_unlock_key_r <= '0;
			nv_write_go_r <= 1'b0;
			load_select_r <= 1'b0;
			lowpower_inhibit_r <= 1'b0;
		end else begin
			if (wr_ok && link.bus_addr == mdpm_pkg::ADDR_SPEED_LO) begin
				speed_command_value_r[7:0] <= link.bus_wdata;
			end
			if (wr_ok && link.bus_addr == mdpm_pkg::ADDR_SPEED_HI) begin
				speed_command_value_r[8] <= link.bus_wdata[0];
			end
			if (wr_ok && link.bus_addr == mdpm_pkg::ADDR_DEV_CTRL) begin
				program_unlock_key_r <= link.bus_wdata;
			end
			if (wr_ok && link.bus_addr == mdpm_pkg::ADDR_NV_CTRL) begin
				load_select_r <= link.bus_wdata[mdpm_pkg::NVC_LOAD_BIT];
				lowpower_inhibit_r <= link.bus_wdata[mdpm_pkg::NVC_INHIBIT_BIT];
				if (link.bus_wdata[mdpm_pkg::NVC_GO_BIT] && program_unlock_key_r == mdpm_pkg::PROG_KEY
						&& load_select_r) begin
					nv_write_go_r <= 1'b1;
				end
			end
			if (prog_done) begin
				nv_write_go_r <= 1'b0;
				program_unlock_key_r <= '0;
			end
		end
	end

	// ----------------------------------------
	// Programming timer
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset || !nv_write_go_r) begin
			prog_ms_r <= '0;
		end else if (tick) begin
			prog_ms_r <= prog_ms_r + 16'h1;
		end
	end

	// ----------------------------------------
	// Working parameters and NV store
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset || sleep_exit) begin
			for (int i = 0; i < mdpm_pkg::NV_BYTES; i++) begin
				work_r[i] <= nv_mem[i];
			end
		end else if (wr_ok && in_nv) begin
			work_r[nv_idx] <= link.bus_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (prog_done) begin
			for (int i = 0; i < mdpm_pkg::NV_BYTES; i++) begin
				nv_mem[i] <= work_r[i];
			end
		end
	end

	assign phase_resistance_code = work_r[mdpm_pkg::IDX_PARAM_A][6:0];
	assign back_emf_constant_code = work_r[mdpm_pkg::IDX_PARAM_B][6:0];

	// ----------------------------------------
	// Low-power entry and exit
	// ----------------------------------------
	logic cond;
	logic [15:0] limit;
	logic [15:0] hold_r;
	logic [7:0] en_lvl;
	logic [7:0] ex_lvl;
	assign en_lvl = SLEEP_VARIANT ? mdpm_pkg::LVL_EN_SL : mdpm_pkg::LVL_EN_SB;
	assign ex_lvl = SLEEP_VARIANT ? mdpm_pkg::LVL_EX_SL : mdpm_pkg::LVL_EX_SB;

	always_comb begin
		cond = 1'b0;
		limit = 16'(EN_ANA_MS);
		if (pm_r == mdpm_pkg::PM_RUN) begin
			case (mode)
				mdpm_pkg::MD_PWM: begin
					cond = !link.speed_pin;
					limit = 16'(EN_PWM_MS);
				end
				mdpm_pkg::MD_I2C: begin
					cond = speed_command_value_r == 9'h000;
					limit = 16'(EN_PWM_MS);
				end
				default: begin
					cond = link.speed_level < en_lvl;
					limit = 16'(EN_ANA_MS);
				end
			endcase
			cond = cond && !lowpower_inhibit_r;
		end else begin
			case (mode)
				mdpm_pkg::MD_PWM: begin
					cond = link.speed_pin;
					limit = 16'(EX_PWM_MS);
				end
				mdpm_pkg::MD_I2C: begin
					cond = SLEEP_VARIANT ? (link.speed_pin || link.speed_level > ex_lvl)
						: speed_command_value_r != 9'h000;
					limit = 16'(EX_PWM_MS);
				end
				default: begin
					cond = link.speed_level > ex_lvl;
					limit = 16'(EX_ANA_MS);
				end
			endcase
		end
	end

	assign trans = cond && hold_r >= limit;

	always_ff @(posedge core_clk) begin
		if (reset || !cond || trans) begin
			hold_r <= '0;
		end else if (tick && hold_r < limit) begin
			hold_r <= hold_r + 16'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pm_r <= mdpm_pkg::PM_RUN;
		end else if (trans) begin
			pm_r <= (pm_r == mdpm_pkg::PM_RUN) ? mdpm_pkg::PM_LOW : mdpm_pkg::PM_RUN;
		end
	end

	assign drive_en = pm_r == mdpm_pkg::PM_RUN;
	assign lowpower = pm_r == mdpm_pkg::PM_LOW;
	assign regulator_en = alive;
	assign link.bus_alive = alive;

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	logic [7:0] rdata_r;
	always_ff @(posedge core_clk) begin
		if (reset || !rd_ok) begin
			rdata_r <= '0;
		end else if (in_nv) begin
			rdata_r <= work_r[nv_idx];
		end else begin
			case (link.bus_addr)
				mdpm_pkg::ADDR_SPEED_LO: rdata_r <= speed_command_value_r[7:0];
				mdpm_pkg::ADDR_SPEED_HI: rdata_r <= {7'h00, speed_command_value_r[8]};
				mdpm_pkg::ADDR_NV_CTRL: rdata_r <= {5'h00, lowpower_inhibit_r, load_select_r, nv_write_go_r};
				mdpm_pkg::ADDR_STATUS: begin
					rdata_r <= '0;
					rdata_r[mdpm_pkg::STAT_LOWPWR_BIT] <= lowpower;
					rdata_r[mdpm_pkg::STAT_BUSY_BIT] <= nv_write_go_r;
				end
				default: rdata_r <= '0;
			endcase
		end
	end
	assign link.bus_rdata = rdata_r;

	// ----------------------------------------
	// Peak duty from selected speed source
	// ----------------------------------------
	logic [7:0] win_r;
	logic [7:0] hi_r;
	logic [7:0] pin_duty_r;
	logic [7:0] cmd_duty;
	logic [8:0] comp_sum;
	always_ff @(posedge core_clk) begin
		if (reset || win_r == mdpm_pkg::CARRIER_TOP) begin
			win_r <= '0;
			hi_r <= '0;
			pin_duty_r <= reset ? 8'h00 : 8'(hi_r + 8'(link.speed_pin));
		end else begin
			win_r <= win_r + 8'h01;
			hi_r <= 8'(hi_r + 8'(link.speed_pin));
		end
	end

	always_comb begin
		case (mode)
			mdpm_pkg::MD_PWM: cmd_duty = pin_duty_r;
			mdpm_pkg::MD_I2C: cmd_duty = speed_command_value_r[8:1];
			default: cmd_duty = link.speed_level;
		endcase
	end
	assign comp_sum = {1'b0, cmd_duty} + {4'h0, phase_resistance_code[6:2]};

	always_ff @(posedge core_clk) begin
		if (reset || cmd_duty == 8'h00) begin
			peak_duty_cycle <= '0;
		end else begin
			peak_duty_cycle <= comp_sum[8] ? 8'hFF : comp_sum[7:0];
		end
	end

	// ----------------------------------------
	// Electrical angle and carrier
	// ----------------------------------------
	logic [11:0] step_r;
	logic [4:0] theta_r;
	logic [7:0] carrier_r;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			step_r <= '0;
			theta_r <= '0;
		end else if (step_r == 12'h000) begin
			step_r <= {back_emf_constant_code, 5'h00};
			theta_r <= (theta_r == 5'(mdpm_pkg::PHASE_STEPS - 1)) ? 5'h00 : theta_r + 5'h01;
		end else begin
			step_r <= step_r - 12'h001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset || carrier_r == mdpm_pkg::CARRIER_TOP) begin
			carrier_r <= '0;
		end else begin
			carrier_r <= carrier_r + 8'h01;
		end
	end

	// ----------------------------------------
	// Pure sine table, lowest phase shifted to zero
	// ----------------------------------------
	function automatic logic [7:0] qsin(input logic [2:0] k);
		case (k)
			3'h0: qsin = 8'h00;
			3'h1: qsin = 8'h21;
			3'h2: qsin = 8'h40;
			3'h3: qsin = 8'h5A;
			3'h4: qsin = 8'h6E;
			3'h5: qsin = 8'h7B;
			default: qsin = 8'h7F;
		endcase
	endfunction

	function automatic logic signed [8:0] sin_at(input logic [5:0] i);
		if (i <= 6'h06) sin_at = $signed({1'b0, qsin(3'(i))});
		else if (i <= 6'h0C) sin_at = $signed({1'b0, qsin(3'(6'h0C - i))});
		else if (i <= 6'h12) sin_at = -$signed({1'b0, qsin(3'(i - 6'h0C))});
		else sin_at = -$signed({1'b0, qsin(3'(6'h18 - i))});
	endfunction

	logic signed [8:0] vph [3];
	logic signed [8:0] vmin;
	assign vmin = (vph[0] < vph[1]) ? ((vph[0] < vph[2]) ? vph[0] : vph[2]) : ((vph[1] < vph[2]) ? vph[1] : vph[2]);

	for (genvar k = 0; k < 3; k++) begin : g_phase
		logic [5:0] sum;
		logic [5:0] idx;
		logic [16:0] prod;
		logic [16:0] quo;
		logic [7:0] duty;
		assign sum = {1'b0, theta_r} + 6'(mdpm_pkg::PHASE_SHIFT * k);
		assign idx = (sum >= 6'(mdpm_pkg::PHASE_STEPS)) ? sum - 6'(mdpm_pkg::PHASE_STEPS) : sum;
		assign vph[k] = sin_at(idx);
		assign prod = 17'(9'(vph[k] - vmin)) * 17'(peak_duty_cycle);
		assign quo = prod / 17'(mdpm_pkg::SIN_SPAN);
		assign duty = (quo > 17'h000FF) ? 8'hFF : quo[7:0];
		always_ff @(posedge core_clk) begin
			if (reset) begin
				phase_pwm[k] <= 1'b0;
			end else begin
				phase_pwm[k] <= drive_en && (carrier_r < duty);
			end
		end
	end
endmodule // mdpm_device
`default_nettype wire

// ### mdpm_pkg.sv
// Shared constants and types for the motor drive power-mode and NV config block
package mdpm_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int PROG_MS = 24;
	localparam int EN_ANA_MS = 50;
	localparam int EN_PWM_MS = 50;
	localparam int EX_ANA_MS = 20;
	localparam int EX_PWM_MS = 20;
	// ----------------------------------------
	// Speed thresholds (analog level codes)
	// ----------------------------------------
	localparam logic [7:0] LVL_EN_SB = 8'h10;
	localparam logic [7:0] LVL_EN_SL = 8'h10;
	localparam logic [7:0] LVL_EX_SB = 8'h20;
	localparam logic [7:0] LVL_EX_SL = 8'h40;
	// ----------------------------------------
	// Device register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_SPEED_LO = 8'h00;
	localparam logic [7:0] ADDR_SPEED_HI = 8'h01;
	localparam logic [7:0] ADDR_DEV_CTRL = 8'h02;
	localparam logic [7:0] ADDR_NV_CTRL = 8'h03;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_NV_FIRST = 8'h20;
	localparam logic [7:0] ADDR_NV_LAST = 8'h2B;
	localparam logic [7:0] ADDR_MODE = 8'h22;
	localparam int NV_BYTES = 12;
	localparam int IDX_PARAM_A = 0;
	localparam int IDX_PARAM_B = 1;
	localparam int IDX_MODE = 2;
	localparam logic [7:0] NV_DEFAULT = 8'h00;
	localparam logic [7:0] PROG_KEY = 8'hB6;
	localparam int NVC_GO_BIT = 0;
	localparam int NVC_LOAD_BIT = 1;
	localparam int NVC_INHIBIT_BIT = 2;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_LOWPWR_BIT = 6;
	// ----------------------------------------
	// Waveform
	// ----------------------------------------
	localparam int PHASE_STEPS = 24;
	localparam int PHASE_SHIFT = 8;
	localparam int SIN_SPAN = 220;
	localparam logic [7:0] CARRIER_TOP = 8'hFE;
	// ----------------------------------------
	// Host register map
	// ----------------------------------------
	localparam logic [4:0] H_PIN = 5'h00;
	localparam logic [4:0] H_LEVEL = 5'h01;
	localparam logic [4:0] H_DADDR = 5'h02;
	localparam logic [4:0] H_DWRITE = 5'h03;
	localparam logic [4:0] H_CMD = 5'h04;
	localparam logic [4:0] H_STAT = 5'h05;
	localparam logic [4:0] H_RESULT = 5'h06;
	localparam logic [4:0] H_BUF_FIRST = 5'h10;
	localparam logic [4:0] H_BUF_LAST = 5'h1B;
	localparam int HCMD_READ_BIT = 0;
	localparam int HCMD_PROG_BIT = 1;
	localparam int HST_REFUSED_BIT = 0;
	localparam int HST_BUSY_BIT = 1;
	localparam int HST_ALIVE_BIT = 2;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {MD_ANALOG = 2'b00, MD_PWM = 2'b01, MD_I2C = 2'b10} mdpm_mode_t;
	typedef enum logic {PM_RUN = 1'b0, PM_LOW = 1'b1} mdpm_pm_t;
	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_LOAD = 3'b001,
		HS_PARAM = 3'b010,
		HS_KEY = 3'b011,
		HS_GO = 3'b100,
		HS_POLL = 3'b101,
		HS_WAIT = 3'b110
	} mdpm_hs_t;
endpackage

// ### mdpm_link_if.sv
// Link between host controller and motor drive device
`timescale 1ns/1ns
`default_nettype none
interface mdpm_link_if;
	logic speed_pin;
	logic [7:0] speed_level;
	logic [7:0] bus_addr;
	logic [7:0] bus_wdata;
	logic bus_wr;
	logic bus_rd;
	logic [7:0] bus_rdata;
	logic bus_alive;
	modport dev (input speed_pin, speed_level, bus_addr, bus_wdata, bus_wr, bus_rd, output bus_rdata, bus_alive);
	modport host (output speed_pin, speed_level, bus_addr, bus_wdata, bus_wr, bus_rd, input bus_rdata, bus_alive);
endinterface
`default_nettype wire

// ### mdpm_host.sv
// Host controller end: speed pin drive, register access, NV programming sequence
`timescale 1ns/1ns
`default_nettype none
module mdpm_host (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Device link
	mdpm_link_if.host link,
	// Software register port
	input wire logic [4:0] sw_addr,
	input wire logic [7:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [7:0] sw_rdata
);
	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	mdpm_pkg::mdpm_hs_t hs_r;
	logic pin_r;
	logic [7:0] level_r;
	logic [7:0] daddr_r;
	logic [7:0] result_r;
	logic refused_r;
	logic [7:0] buf_r [mdpm_pkg::NV_BYTES];
	logic [3:0] idx_r;
	logic rd_d_r;
	logic in_buf;
	logic req_write;
	logic req_read;
	logic req_prog;
	logic refuse;

	assign in_buf = sw_addr >= mdpm_pkg::H_BUF_FIRST && sw_addr <= mdpm_pkg::H_BUF_LAST;
	assign req_write = sw_wr && sw_addr == mdpm_pkg::H_DWRITE;
	assign req_read = sw_wr && sw_addr == mdpm_pkg::H_CMD && sw_wdata[mdpm_pkg::HCMD_READ_BIT];
	assign req_prog = sw_wr && sw_addr == mdpm_pkg::H_CMD && sw_wdata[mdpm_pkg::HCMD_PROG_BIT];
	// Bus requests need an awake device and an idle sequencer
	assign refuse = (req_write || req_read || req_prog)
		&& (hs_r != mdpm_pkg::HS_IDLE || !link.bus_alive || (req_prog && pin_r));

	always_ff @(posedge core_clk) begin
		if (reset) begin
			pin_r <= 1'b0;
			level_r <= '0;
			daddr_r <= '0;
			refused_r <= 1'b0;
		end else begin
			if (sw_wr && sw_addr == mdpm_pkg::H_PIN) pin_r <= sw_wdata[0];
			if (sw_wr && sw_addr == mdpm_pkg::H_LEVEL) level_r <= sw_wdata;
			if (sw_wr && sw_addr == mdpm_pkg::H_DADDR) daddr_r <= sw_wdata;
			if (refuse) begin
				refused_r <= 1'b1;
			end else if (sw_wr && sw_addr == mdpm_pkg::H_STAT && sw_wdata[mdpm_pkg::HST_REFUSED_BIT]) begin
				refused_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < mdpm_pkg::NV_BYTES; i++) begin
				buf_r[i] <= '0;
			end
		end else if (sw_wr && in_buf) begin
			buf_r[4'(sw_addr - mdpm_pkg::H_BUF_FIRST)] <= sw_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset || !sw_rd) begin
			sw_rdata <= '0;
		end else if (in_buf) begin
			sw_rdata <= buf_r[4'(sw_addr - mdpm_pkg::H_BUF_FIRST)];
		end else begin
			case (sw_addr)
				mdpm_pkg::H_PIN: sw_rdata <= {7'h00, pin_r};
				mdpm_pkg::H_LEVEL: sw_rdata <= level_r;
				mdpm_pkg::H_DADDR: sw_rdata <= daddr_r;
				mdpm_pkg::H_STAT: sw_rdata <= {5'h00, link.bus_alive, hs_r != mdpm_pkg::HS_IDLE, refused_r};
				mdpm_pkg::H_RESULT: sw_rdata <= result_r;
				default: sw_rdata <= '0;
			endcase
		end
	end

	assign link.speed_pin = pin_r;
	assign link.speed_level = level_r;

	// ----------------------------------------
	// Link master and programming sequence
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			hs_r <= mdpm_pkg::HS_IDLE;
			link.bus_wr <= 1'b0;
			link.bus_rd <= 1'b0;
			link.bus_addr <= '0;
			link.bus_wdata <= '0;
			idx_r <= '0;
		end else begin
			link.bus_wr <= 1'b0;
			link.bus_rd <= 1'b0;
			case (hs_r)
				mdpm_pkg::HS_IDLE: begin
					if (!refuse && req_write) begin
						link.bus_wr <= 1'b1;
						link.bus_addr <= daddr_r;
						link.bus_wdata <= sw_wdata;
					end else if (!refuse && req_read) begin
						link.bus_rd <= 1'b1;
						link.bus_addr <= daddr_r;
					end else if (!refuse && req_prog) begin
						hs_r <= mdpm_pkg::HS_LOAD;
					end
				end
				mdpm_pkg::HS_LOAD: begin
					link.bus_wr <= 1'b1;
					link.bus_addr <= mdpm_pkg::ADDR_NV_CTRL;
					link.bus_wdata <= 8'(1 << mdpm_pkg::NVC_LOAD_BIT);
					idx_r <= '0;
					hs_r <= mdpm_pkg::HS_PARAM;
				end
				mdpm_pkg::HS_PARAM: begin
					link.bus_wr <= 1'b1;
					link.bus_addr <= mdpm_pkg::ADDR_NV_FIRST + 8'(idx_r);
					link.bus_wdata <= buf_r[idx_r];
					idx_r <= idx_r + 4'h1;
					if (idx_r == 4'(mdpm_pkg::NV_BYTES - 1)) hs_r <= mdpm_pkg::HS_KEY;
				end
				mdpm_pkg::HS_KEY: begin
					link.bus_wr <= 1'b1;
					link.bus_addr <= mdpm_pkg::ADDR_DEV_CTRL;
					link.bus_wdata <= mdpm_pkg::PROG_KEY;
					hs_r <= mdpm_pkg::HS_GO;
				end
				mdpm_pkg::HS_GO: begin
					link.bus_wr <= 1'b1;
					link.bus_addr <= mdpm_pkg::ADDR_NV_CTRL;
					link.bus_wdata <= 8'((1 << mdpm_pkg::NVC_LOAD_BIT) | (1 << mdpm_pkg::NVC_GO_BIT));
					hs_r <= mdpm_pkg::HS_POLL;
				end
				mdpm_pkg::HS_POLL: begin
					link.bus_rd <= 1'b1;
					link.bus_addr <= mdpm_pkg::ADDR_NV_CTRL;
					hs_r <= mdpm_pkg::HS_WAIT;
				end
				mdpm_pkg::HS_WAIT: begin
					if (rd_d_r) begin
						hs_r <= link.bus_rdata[mdpm_pkg::NVC_GO_BIT] ? mdpm_pkg::HS_POLL : mdpm_pkg::HS_IDLE;
					end
				end
				default: hs_r <= mdpm_pkg::HS_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Read result capture
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rd_d_r <= 1'b0;
			result_r <= '0;
		end else begin
			rd_d_r <= link.bus_rd;
			if (rd_d_r) result_r <= link.bus_rdata;
		end
	end
endmodule // mdpm_host
`default_nettype wire

// ### mdpm_link_props.sv
// Concurrent checks on the host-device link
`timescale 1ns/1ns
`default_nettype none
module mdpm_link_props (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Link signals
	input wire logic speed_pin,
	input wire logic [7:0] speed_level,
	input wire logic [7:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic bus_alive
);
	logic key_r;
	logic load_r;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	always_ff @(posedge core_clk) begin
		key_r <= !reset && (key_r || (bus_wr && bus_addr == 8'h02 && bus_wdata == 8'hB6));
	end
	always_ff @(posedge core_clk) begin
		load_r <= !reset && (load_r || (bus_wr && bus_addr == 8'h03 && bus_wdata[1]));
	end
	dead_read_a: assert property (
		!bus_alive |=> bus_rdata == 8'h00) else $error("read answered while asleep");
	key_hidden_a: assert property (
		bus_rd && bus_addr == 8'h02 |=> bus_rdata == 8'h00) else $error("key readable");
	go_locked_a: assert property (
		bus_rd && bus_addr == 8'h03 && !key_r |=> !bus_rdata[0]) else $error("go set without key");
	key_after_a: assert property (
		bus_wr && bus_addr == 8'h02 && bus_wdata == 8'hB6 |-> load_r && $past(bus_addr) == 8'h2B)
		else $error("key before load and parameters");
	go_order_a: assert property (
		bus_wr && bus_addr == 8'h03 && bus_wdata[0] |-> $past(bus_wr) && $past(bus_wdata) == 8'hB6)
		else $error("go not right after key");
	nv_span_a: assert property (
		bus_rd && bus_addr > 8'h2B |=> bus_rdata == 8'h00) else $error("read beyond store");
	wake_cause_a: assert property (
		$rose(bus_alive) |-> $past(speed_pin) || $past(speed_level) > 8'h40) else $error("wake without pin");
	flag_low_a: assert property (
		bus_rd && bus_addr == 8'h10 && bus_alive |=> !bus_rdata[6]) else $error("flag while awake");
	cover property ($rose(bus_alive));
	cover property ($fell(bus_alive));
	cover property (bus_wr && bus_addr == 8'h03 && bus_wdata[0]);
endmodule // mdpm_link_props
`default_nettype wire

// ### tb_mdpm.sv
// Testbench joining host and device ends
`timescale 1ns/1ns
`default_nettype none
module tb_mdpm;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [4:0] sw_addr = 5'h00;
	logic [7:0] sw_wdata = 8'h00;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic [7:0] sw_rdata, d;
	logic [2:0] phase_pwm;
	logic drive_en, regulator_en, lowpower;
	logic [6:0] res_code, emf_code;
	logic [7:0] peak;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	int n;
	mdpm_link_if mdpm_link_if_inst ();
	mdpm_device #(.TICK_CYCLES(10), .PROG_MS(3), .EN_ANA_MS(3), .EN_PWM_MS(3), .EX_PWM_MS(2))
		mdpm_device_inst (.core_clk(core_clk), .reset(reset), .link(mdpm_link_if_inst), .phase_pwm(phase_pwm),
		.drive_en(drive_en), .regulator_en(regulator_en), .lowpower(lowpower), .peak_duty_cycle(peak),
		.phase_resistance_code(res_code), .back_emf_constant_code(emf_code));
	mdpm_host mdpm_host_inst (.core_clk(core_clk), .reset(reset), .link(mdpm_link_if_inst), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
	mdpm_link_props mdpm_link_props_inst (.core_clk(core_clk), .reset(reset),
		.speed_pin(mdpm_link_if_inst.speed_pin), .speed_level(mdpm_link_if_inst.speed_level),
		.bus_addr(mdpm_link_if_inst.bus_addr), .bus_wdata(mdpm_link_if_inst.bus_wdata),
		.bus_wr(mdpm_link_if_inst.bus_wr), .bus_rd(mdpm_link_if_inst.bus_rd),
		.bus_rdata(mdpm_link_if_inst.bus_rdata), .bus_alive(mdpm_link_if_inst.bus_alive));
	initial forever #10 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic sw_write(input logic [4:0] a, input logic [7:0] v);
		@(posedge core_clk);
		sw_addr <= a;
		sw_wdata <= v;
		sw_wr <= 1'b1;
		@(posedge core_clk);
		sw_wr <= 1'b0;
	endtask
	task automatic sw_get(input logic [4:0] a);
		@(posedge core_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge core_clk);
		sw_rd <= 1'b0;
		#1 d = sw_rdata;
	endtask
	task automatic sw_read(input logic [4:0] a, input string name, input logic [7:0] exp);
		sw_get(a);
		check(name, d, exp);
	endtask
	task automatic dev_wr(input logic [7:0] a, input logic [7:0] v);
		sw_write(5'h02, a);
		sw_write(5'h03, v);
	endtask
	task automatic dev_rd(input logic [7:0] a, input string name, input logic [7:0] exp);
		sw_write(5'h02, a);
		sw_write(5'h04, 8'h01);
		repeat (4) @(posedge core_clk);
		sw_read(5'h06, name, exp);
	endtask
	task automatic wait_lp(input logic v);
		for (n = 0; lowpower !== v && n < 400; n++) begin
			@(posedge core_clk);
			#1;
		end
		check("lowpower", {7'h00, lowpower}, {7'h00, v});
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		check("regulator", {7'h00, regulator_en}, 8'h01);
		sw_write(5'h01, 8'h80);
		sw_read(5'h05, "host status", 8'h04);
		$display("reset test done");
		sw_write(5'h10, 8'h15);
		sw_write(5'h11, 8'h2A);
		sw_write(5'h04, 8'h02);
		n = 0;
		do sw_get(5'h05);
		while (d[1] === 1'b1 && ++n < 99);
		check("program length", {7'h00, n >= 15 && n < 99}, 8'h01);
		check("resistance", {1'b0, res_code}, 8'h15);
		check("back emf", {1'b0, emf_code}, 8'h2A);
		check("peak duty", peak, 8'h85);
		dev_rd(8'h03, "nv control", 8'h02);
		dev_rd(8'h02, "key", 8'h00);
		dev_rd(8'h40, "unmapped", 8'h00);
		dev_rd(8'h10, "status", 8'h00);
		$display("program test done");
		sw_write(5'h00, 8'h01);
		dev_wr(8'h22, 8'h01);
		dev_wr(8'h20, 8'h33);
		repeat (2) @(posedge core_clk);
		check("override", {1'b0, res_code}, 8'h33);
		sw_write(5'h00, 8'h00);
		wait_lp(1'b1);
		repeat (2) @(posedge core_clk);
		check("drive", {4'h0, phase_pwm, drive_en}, 8'h00);
		check("regulator", {7'h00, regulator_en}, 8'h00);
		sw_write(5'h04, 8'h01);
		sw_read(5'h05, "refused", 8'h01);
		sw_write(5'h00, 8'h01);
		wait_lp(1'b0);
		check("reloaded", {1'b0, res_code}, 8'h15);
		sw_write(5'h05, 8'h01);
		sw_write(5'h00, 8'h00);
		dev_wr(8'h03, 8'h04);
		sw_write(5'h01, 8'h00);
		repeat (100) @(posedge core_clk);
		check("inhibited", {7'h00, lowpower}, 8'h00);
		dev_wr(8'h03, 8'h00);
		wait_lp(1'b1);
		sw_write(5'h01, 8'h30);
		repeat (100) @(posedge core_clk);
		check("below exit", {7'h00, lowpower}, 8'h01);
		sw_write(5'h01, 8'h41);
		wait_lp(1'b0);
		dev_wr(8'h00, 8'h05);
		dev_wr(8'h22, 8'h02);
		sw_write(5'h01, 8'h00);
		repeat (100) @(posedge core_clk);
		check("command held", {7'h00, lowpower}, 8'h00);
		dev_wr(8'h00, 8'h00);
		wait_lp(1'b1);
		sw_write(5'h00, 8'h01);
		wait_lp(1'b0);
		$display("power test done");
		print_verdict();
	end
endmodule // tb_mdpm
`default_nettype wire
